// *** core/fprs_cfg.svh ***
`ifndef FPRS_CFG_SVH
`define FPRS_CFG_SVH

`define FPRS_NUM_REGS 32
`define FPRS_ADDR_FFLAGS 12'h001
`define FPRS_ADDR_FRM 12'h002
`define FPRS_ADDR_FCSR 12'h003
`define FPRS_ADDR_MSTATUS 12'h300

`define FPRS_FS_OFF 2'h0
`define FPRS_FS_INITIAL 2'h1
`define FPRS_FS_CLEAN 2'h2
`define FPRS_FS_DIRTY 2'h3

`define FPRS_FS_LSB 13
`define FPRS_SD_POS 31
`define FPRS_FRM_LSB 5
`define FPRS_FLAGS_W 5
`define FPRS_FRM_W 3

`define FPRS_FS_RST 2'h0
`define FPRS_FFLAGS_RST 5'h00
`define FPRS_FRM_RST 3'h0

`endif

// *** core/fprs_pkg.sv ***
package fprs_pkg;
    typedef logic [31:0] fprs_word_t;
    typedef logic [4:0] fprs_ridx_t;
    typedef logic [1:0] fprs_fs_t;
    // which source owns the single register-file write slot this cycle
    typedef enum logic [1:0] {
        FPRS_WSRC_NONE,
        FPRS_WSRC_PIPE,
        FPRS_WSRC_HOLD,
        FPRS_WSRC_BG
    } fprs_wsrc_t;
endpackage : fprs_pkg

// *** core/fprs_rf_if.sv ***
`timescale 1ns/1ns
interface fprs_rf_if;
    logic we;
    fprs_pkg::fprs_ridx_t waddr;
    fprs_pkg::fprs_word_t wdata;
    fprs_pkg::fprs_ridx_t raddr [3];
    fprs_pkg::fprs_word_t rdata [3];
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport rf (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : fprs_rf_if

// *** core/fprs_regfile.sv ***
`timescale 1ns/1ns
`include "fprs_cfg.svh"
module fprs_regfile (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    fprs_rf_if.rf rf
);
    fprs_pkg::fprs_word_t mem_q [`FPRS_NUM_REGS];

    // register contents are not reset; software initialises them
    always_ff @(posedge i_clk_sys) begin
        if (rf.we) begin
            mem_q[rf.waddr] <= rf.wdata;
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            rf.rdata[i] = mem_q[rf.raddr[i]];
        end
    end

    AST_RF_WRITE_READ: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        rf.we ##1 (rf.raddr[0] == $past(rf.waddr)) |-> (rf.rdata[0] == $past(rf.wdata)))
        else $error("register file lost a written word");
endmodule : fprs_regfile

// *** core/fprs_top.sv ***
`timescale 1ns/1ns
`include "fprs_cfg.svh"
module fprs_top #(
    parameter bit P_INT_REUSE = 1'b0
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_core_sleep,
    output logic o_fpu_clk_en,
    input wire fprs_pkg::fprs_ridx_t i_rd_addr_a,
    input wire fprs_pkg::fprs_ridx_t i_rd_addr_b,
    input wire fprs_pkg::fprs_ridx_t i_rd_addr_c,
    output fprs_pkg::fprs_word_t o_rd_data_a,
    output fprs_pkg::fprs_word_t o_rd_data_b,
    output fprs_pkg::fprs_word_t o_rd_data_c,
    input wire fprs_pkg::fprs_word_t i_gpr_rdata_a,
    input wire fprs_pkg::fprs_word_t i_gpr_rdata_b,
    input wire fprs_pkg::fprs_word_t i_gpr_rdata_c,
    output logic o_gpr_we,
    output fprs_pkg::fprs_ridx_t o_gpr_waddr,
    output fprs_pkg::fprs_word_t o_gpr_wdata,
    input wire logic i_wr_en,
    input wire fprs_pkg::fprs_ridx_t i_wr_addr,
    input wire fprs_pkg::fprs_word_t i_wr_data,
    input wire logic i_bg_issue,
    input wire fprs_pkg::fprs_ridx_t i_bg_issue_rd,
    input wire logic i_bg_wr_en,
    input wire fprs_pkg::fprs_ridx_t i_bg_addr,
    input wire fprs_pkg::fprs_word_t i_bg_data,
    output logic o_bg_ready,
    input wire logic i_dec_valid,
    input wire logic [2:0] i_dec_rs_use,
    input wire fprs_pkg::fprs_ridx_t i_dec_rs1,
    input wire fprs_pkg::fprs_ridx_t i_dec_rs2,
    input wire fprs_pkg::fprs_ridx_t i_dec_rs3,
    input wire logic i_dec_rd_use,
    input wire fprs_pkg::fprs_ridx_t i_dec_rd,
    output logic o_dec_stall,
    input wire logic i_fp_instr,
    input wire logic i_flags_valid,
    input wire logic [`FPRS_FLAGS_W-1:0] i_flags,
    input wire logic i_csr_en,
    input wire logic i_csr_we,
    input wire logic [11:0] i_csr_addr,
    input wire fprs_pkg::fprs_word_t i_csr_wdata,
    output fprs_pkg::fprs_word_t o_csr_rdata,
    output logic o_illegal,
    output logic [`FPRS_FLAGS_W-1:0] o_fflags,
    output logic [`FPRS_FRM_W-1:0] o_frm,
    output fprs_pkg::fprs_fs_t o_fs,
    output logic o_sd
);
    fprs_rf_if rf_bus ();

    fprs_pkg::fprs_fs_t fs_q, fs_d;
    logic [`FPRS_FLAGS_W-1:0] fflags_q, fflags_d;
    logic [`FPRS_FRM_W-1:0] frm_q, frm_d;
    logic [`FPRS_NUM_REGS-1:0] pend_q, pend_d;
    logic hold_v_q, hold_v_d;
    fprs_pkg::fprs_ridx_t hold_addr_q;
    fprs_pkg::fprs_word_t hold_data_q;
    fprs_pkg::fprs_wsrc_t wsrc;
    logic w_en;
    fprs_pkg::fprs_ridx_t w_addr;
    fprs_pkg::fprs_word_t w_data;
    logic fp_csr_acc, fp_csr_wr, ms_wr, dirty_ev;

    function automatic logic is_fp_csr(input logic [11:0] a);
        is_fp_csr = (a == `FPRS_ADDR_FFLAGS) || (a == `FPRS_ADDR_FRM)
                    || (a == `FPRS_ADDR_FCSR);
    endfunction : is_fp_csr

    function automatic logic pend_hit(input logic [`FPRS_NUM_REGS-1:0] p,
                                      input logic use_it, input fprs_pkg::fprs_ridx_t r);
        pend_hit = use_it && p[r];
    endfunction : pend_hit

    // clock gating enable for the fpu
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fpu_clk_en <= 1'b1;
        end else begin
            o_fpu_clk_en <= ~i_core_sleep;
        end
    end

    // single write slot: pipeline first, then the parked background result, then a fresh one
    always_comb begin
        if (i_wr_en) begin
            wsrc = fprs_pkg::FPRS_WSRC_PIPE;
        end else if (hold_v_q) begin
            wsrc = fprs_pkg::FPRS_WSRC_HOLD;
        end else if (i_bg_wr_en) begin
            wsrc = fprs_pkg::FPRS_WSRC_BG;
        end else begin
            wsrc = fprs_pkg::FPRS_WSRC_NONE;
        end
    end

    always_comb begin
        w_en = 1'b1;
        w_addr = i_wr_addr;
        w_data = i_wr_data;
        case (wsrc)
            fprs_pkg::FPRS_WSRC_PIPE: begin
            end
            fprs_pkg::FPRS_WSRC_HOLD: begin
                w_addr = hold_addr_q;
                w_data = hold_data_q;
            end
            fprs_pkg::FPRS_WSRC_BG: begin
                w_addr = i_bg_addr;
                w_data = i_bg_data;
            end
            default: begin
                w_en = 1'b0;
            end
        endcase
    end

    // a background result is parked when it cannot take the slot, except one arriving while the park slot is full and the pipeline writes
    always_comb begin
        hold_v_d = (i_wr_en && (hold_v_q || i_bg_wr_en)) || (hold_v_q && i_bg_wr_en);
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_v_q <= 1'b0;
            hold_addr_q <= 5'h00;
            hold_data_q <= 32'h0000_0000;
            o_bg_ready <= 1'b1;
        end else begin
            hold_v_q <= hold_v_d;
            if (i_bg_wr_en && (hold_v_q || i_wr_en) && !(hold_v_q && i_wr_en)) begin
                hold_addr_q <= i_bg_addr;
                hold_data_q <= i_bg_data;
            end
            // ready drops while the park slot is full so no result can be overrun
            o_bg_ready <= ~hold_v_d;
        end
    end

    // scoreboard of destinations still owed a background result
    always_comb begin
        pend_d = pend_q;
        if (w_en && (wsrc != fprs_pkg::FPRS_WSRC_PIPE)) begin
            pend_d[w_addr] = 1'b0;
        end
        if (i_bg_issue) begin
            pend_d[i_bg_issue_rd] = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_q <= 32'h0000_0000;
            o_dec_stall <= 1'b0;
        end else begin
            pend_q <= pend_d;
            o_dec_stall <= i_dec_valid && (pend_hit(pend_q, i_dec_rs_use[0], i_dec_rs1)
                || pend_hit(pend_q, i_dec_rs_use[1], i_dec_rs2)
                || pend_hit(pend_q, i_dec_rs_use[2], i_dec_rs3)
                || pend_hit(pend_q, i_dec_rd_use, i_dec_rd));
        end
    end

    // storage either local or borrowed from the integer file
    assign rf_bus.we = w_en && !P_INT_REUSE;
    assign rf_bus.waddr = w_addr;
    assign rf_bus.wdata = w_data;
    assign rf_bus.raddr[0] = i_rd_addr_a;
    assign rf_bus.raddr[1] = i_rd_addr_b;
    assign rf_bus.raddr[2] = i_rd_addr_c;

    generate
        if (!P_INT_REUSE) begin : g_own_rf
            fprs_regfile u_rf (
                .i_clk_sys(i_clk_sys),
                .i_sys_rst(i_sys_rst),
                .rf(rf_bus.rf)
            );
        end else begin : g_no_rf
            assign rf_bus.rdata[0] = 32'h0000_0000;
            assign rf_bus.rdata[1] = 32'h0000_0000;
            assign rf_bus.rdata[2] = 32'h0000_0000;
        end
    endgenerate

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_data_a <= 32'h0000_0000;
            o_rd_data_b <= 32'h0000_0000;
            o_rd_data_c <= 32'h0000_0000;
            o_gpr_we <= 1'b0;
            o_gpr_waddr <= 5'h00;
            o_gpr_wdata <= 32'h0000_0000;
        end else begin
            o_rd_data_a <= P_INT_REUSE ? i_gpr_rdata_a : rf_bus.rdata[0];
            o_rd_data_b <= P_INT_REUSE ? i_gpr_rdata_b : rf_bus.rdata[1];
            o_rd_data_c <= P_INT_REUSE ? i_gpr_rdata_c : rf_bus.rdata[2];
            o_gpr_we <= w_en && P_INT_REUSE;
            o_gpr_waddr <= w_addr;
            o_gpr_wdata <= w_data;
        end
    end

    // control/status state
    assign fp_csr_acc = i_csr_en && is_fp_csr(i_csr_addr);
    assign fp_csr_wr = fp_csr_acc && i_csr_we && (fs_q != `FPRS_FS_OFF);
    assign ms_wr = i_csr_en && i_csr_we && (i_csr_addr == `FPRS_ADDR_MSTATUS);
    assign dirty_ev = i_wr_en || i_bg_wr_en || i_flags_valid || fp_csr_wr;

    always_comb begin
        fflags_d = fflags_q;
        frm_d = frm_q;
        if (fp_csr_wr) begin
            case (i_csr_addr)
                `FPRS_ADDR_FFLAGS: fflags_d = i_csr_wdata[`FPRS_FLAGS_W-1:0];
                `FPRS_ADDR_FRM: frm_d = i_csr_wdata[`FPRS_FRM_W-1:0];
                default: begin
                    fflags_d = i_csr_wdata[`FPRS_FLAGS_W-1:0];
                    frm_d = i_csr_wdata[`FPRS_FRM_LSB +: `FPRS_FRM_W];
                end
            endcase
        end
        // a flag raised in the same cycle as a clear still sticks
        if (i_flags_valid) begin
            fflags_d = fflags_d | i_flags;
        end
        fs_d = ms_wr ? i_csr_wdata[`FPRS_FS_LSB +: 2] : fs_q;
        if (dirty_ev && (fs_q != `FPRS_FS_OFF)) begin
            fs_d = `FPRS_FS_DIRTY;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fs_q <= `FPRS_FS_RST;
            fflags_q <= `FPRS_FFLAGS_RST;
            frm_q <= `FPRS_FRM_RST;
        end else begin
            fs_q <= fs_d;
            fflags_q <= fflags_d;
            frm_q <= frm_d;
        end
    end

    // outputs mirror next state so they stay aligned with the internal copies
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fs <= `FPRS_FS_RST;
            o_sd <= 1'b0;
            o_fflags <= `FPRS_FFLAGS_RST;
            o_frm <= `FPRS_FRM_RST;
        end else begin
            o_fs <= fs_d;
            o_sd <= (fs_d == `FPRS_FS_DIRTY);
            o_fflags <= fflags_d;
            o_frm <= frm_d;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_illegal <= 1'b0;
            o_csr_rdata <= 32'h0000_0000;
        end else begin
            o_illegal <= (i_fp_instr || fp_csr_acc) && (fs_q == `FPRS_FS_OFF);
            o_csr_rdata <= 32'h0000_0000;
            if (i_csr_en && !(fp_csr_acc && (fs_q == `FPRS_FS_OFF))) begin
                case (i_csr_addr)
                    `FPRS_ADDR_FFLAGS: o_csr_rdata[`FPRS_FLAGS_W-1:0] <= fflags_q;
                    `FPRS_ADDR_FRM: o_csr_rdata[`FPRS_FRM_W-1:0] <= frm_q;
                    `FPRS_ADDR_FCSR: o_csr_rdata[7:0] <= {frm_q, fflags_q};
                    `FPRS_ADDR_MSTATUS: begin
                        o_csr_rdata[`FPRS_FS_LSB +: 2] <= fs_q;
                        o_csr_rdata[`FPRS_SD_POS] <= (fs_q == `FPRS_FS_DIRTY);
                    end
                    default: o_csr_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    AST_CLK_EN: assert property (i_core_sleep |=> !o_fpu_clk_en)
        else $error("fpu clock enabled while core sleeps");
    AST_FLAGS_STICK: assert property (i_flags_valid |=> ((o_fflags & $past(i_flags)) == $past(i_flags)))
        else $error("raised flag not accrued");
    AST_FCSR_VIEW: assert property ((fp_csr_wr && i_csr_addr == `FPRS_ADDR_FCSR && !i_flags_valid)
        |=> o_frm == $past(i_csr_wdata[7:5]) && o_fflags == $past(i_csr_wdata[4:0]))
        else $error("combined view write not split into fields");
    AST_ILLEGAL_OFF: assert property ((i_fp_instr && fs_q == `FPRS_FS_OFF) |=> o_illegal)
        else $error("fp access while off not flagged");
    AST_NO_ILLEGAL_ON: assert property ((fs_q != `FPRS_FS_OFF) |=> !o_illegal)
        else $error("illegal raised while fp state enabled");
    AST_SD_DIRTY: assert property (o_sd == (o_fs == `FPRS_FS_DIRTY))
        else $error("summary dirty bit disagrees with state field");
    AST_STALL_PEND: assert property ((i_bg_issue && !i_bg_wr_en && !hold_v_q) ##1
        (i_dec_valid && i_dec_rs_use[0] && i_dec_rs1 == $past(i_bg_issue_rd)) |=> o_dec_stall)
        else $error("dependent instruction not stalled");
    AST_HOLD_DRAIN: assert property ((hold_v_q && !i_wr_en) |-> wsrc == fprs_pkg::FPRS_WSRC_HOLD)
        else $error("parked result not drained into free slot");
    AST_PIPE_WINS: assert property ((i_wr_en && i_bg_wr_en && !hold_v_q) |=> hold_v_q && !o_bg_ready)
        else $error("background result not parked behind pipeline write");
    AST_DIRTY_SET: assert property ((i_wr_en && fs_q != `FPRS_FS_OFF) |=> o_fs == `FPRS_FS_DIRTY)
        else $error("fp write did not mark state dirty");

    COV_DIRTY: cover property (fs_q == `FPRS_FS_INITIAL ##1 fs_q == `FPRS_FS_DIRTY);
    COV_PARK: cover property (i_wr_en && i_bg_wr_en);
    COV_STALL: cover property (o_dec_stall);
    COV_ILLEGAL: cover property (o_illegal);
endmodule : fprs_top

// *** tb/fprs_fpu_model.sv ***
`timescale 1ns/1ns
// background unit: a result is handed over only while the block says it can take it
module fprs_fpu_model (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire fprs_pkg::fprs_ridx_t i_rd,
    input wire fprs_pkg::fprs_word_t i_res,
    input wire logic i_fire,
    input wire logic i_bg_ready,
    output logic o_issue,
    output fprs_pkg::fprs_ridx_t o_issue_rd,
    output logic o_wr_en,
    output fprs_pkg::fprs_ridx_t o_addr,
    output fprs_pkg::fprs_word_t o_data
);
    logic pend_q;
    fprs_pkg::fprs_ridx_t rd_q;
    fprs_pkg::fprs_word_t res_q;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_issue <= 1'b0;
            o_issue_rd <= 5'h00;
            o_wr_en <= 1'b0;
            o_addr <= 5'h00;
            o_data <= 32'h0000_0000;
            pend_q <= 1'b0;
            rd_q <= 5'h00;
            res_q <= 32'h0000_0000;
        end else begin
            o_issue <= i_start;
            o_issue_rd <= i_start ? i_rd : ~o_issue_rd;
            // idle lines toggle so a stale value never passes for a real one
            o_wr_en <= 1'b0;
            o_addr <= ~o_addr;
            o_data <= ~o_data;
            if (i_start) begin
                pend_q <= 1'b1;
                rd_q <= i_rd;
                res_q <= i_res;
            end else if (pend_q && i_fire && i_bg_ready) begin
                o_wr_en <= 1'b1;
                o_addr <= rd_q;
                o_data <= res_q;
                pend_q <= 1'b0;
            end
        end
    end
endmodule : fprs_fpu_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`include "fprs_cfg.svh"
module tb_top;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_core_sleep = 0, i_wr_en = 0, i_dec_valid = 0, i_dec_rd_use = 0, i_fp_instr = 0;
    logic i_flags_valid = 0, i_csr_en = 0, i_csr_we = 0, m_start = 0, m_fire = 0, ill;
    logic [2:0] i_dec_rs_use = 0;
    logic [4:0] i_flags = 0;
    logic [11:0] i_csr_addr = 0;
    logic [2:0] x_frm;
    logic [4:0] x_ff;
    fprs_pkg::fprs_ridx_t i_rd_addr_a = 0, i_rd_addr_b = 0, i_rd_addr_c = 0, i_wr_addr = 0;
    fprs_pkg::fprs_ridx_t i_dec_rs1 = 0, i_dec_rs2 = 5'h1f, i_dec_rs3 = 5'h1e, i_dec_rd = 0;
    fprs_pkg::fprs_ridx_t m_rd = 0;
    fprs_pkg::fprs_word_t i_wr_data = 0, i_csr_wdata = 0, m_res = 0, rdv, rv;
    fprs_pkg::fprs_word_t gpr_a = 0, gpr_b = 0, gpr_c = 0;
    fprs_pkg::fprs_word_t exp_rf [32];
    wire fprs_pkg::fprs_word_t rd_a, rd_b, rd_c, gpr_wdata, bg_data, csr_rdata;
    wire fprs_pkg::fprs_ridx_t gpr_waddr, bg_issue_rd, bg_addr;
    wire fprs_pkg::fprs_word_t rr_a, rr_b, rr_c, rgpr_wdata;
    wire fprs_pkg::fprs_ridx_t rgpr_waddr;
    wire logic rgpr_we;
    wire logic fpu_clk_en, gpr_we, bg_issue, bg_wr_en, bg_ready, dec_stall, illegal, sd;
    wire logic [4:0] fflags;
    wire logic [2:0] frm;
    wire fprs_pkg::fprs_fs_t fs;
    integer seed = 35, num_errors = 0, check_count = 0, i;

    fprs_top DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_core_sleep(i_core_sleep),
        .o_fpu_clk_en(fpu_clk_en), .i_rd_addr_a(i_rd_addr_a), .i_rd_addr_b(i_rd_addr_b),
        .i_rd_addr_c(i_rd_addr_c), .o_rd_data_a(rd_a), .o_rd_data_b(rd_b), .o_rd_data_c(rd_c),
        .i_gpr_rdata_a(gpr_a), .i_gpr_rdata_b(gpr_b), .i_gpr_rdata_c(gpr_c),
        .o_gpr_we(gpr_we), .o_gpr_waddr(gpr_waddr), .o_gpr_wdata(gpr_wdata),
        .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
        .i_bg_issue(bg_issue), .i_bg_issue_rd(bg_issue_rd), .i_bg_wr_en(bg_wr_en),
        .i_bg_addr(bg_addr), .i_bg_data(bg_data), .o_bg_ready(bg_ready),
        .i_dec_valid(i_dec_valid), .i_dec_rs_use(i_dec_rs_use), .i_dec_rs1(i_dec_rs1),
        .i_dec_rs2(i_dec_rs2), .i_dec_rs3(i_dec_rs3), .i_dec_rd_use(i_dec_rd_use),
        .i_dec_rd(i_dec_rd), .o_dec_stall(dec_stall), .i_fp_instr(i_fp_instr),
        .i_flags_valid(i_flags_valid), .i_flags(i_flags), .i_csr_en(i_csr_en),
        .i_csr_we(i_csr_we), .i_csr_addr(i_csr_addr), .i_csr_wdata(i_csr_wdata),
        .o_csr_rdata(csr_rdata), .o_illegal(illegal), .o_fflags(fflags), .o_frm(frm),
        .o_fs(fs), .o_sd(sd));
    fprs_fpu_model u_fpu (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_start(m_start),
        .i_rd(m_rd), .i_res(m_res), .i_fire(m_fire), .i_bg_ready(bg_ready),
        .o_issue(bg_issue), .o_issue_rd(bg_issue_rd), .o_wr_en(bg_wr_en), .o_addr(bg_addr),
        .o_data(bg_data));
    // second copy built for integer-file reuse, fed the same stimulus
    fprs_top #(.P_INT_REUSE(1'b1)) DUT_INT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_core_sleep(i_core_sleep), .o_fpu_clk_en(), .i_rd_addr_a(i_rd_addr_a),
        .i_rd_addr_b(i_rd_addr_b), .i_rd_addr_c(i_rd_addr_c), .o_rd_data_a(rr_a),
        .o_rd_data_b(rr_b), .o_rd_data_c(rr_c), .i_gpr_rdata_a(gpr_a), .i_gpr_rdata_b(gpr_b),
        .i_gpr_rdata_c(gpr_c), .o_gpr_we(rgpr_we), .o_gpr_waddr(rgpr_waddr),
        .o_gpr_wdata(rgpr_wdata), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
        .i_wr_data(i_wr_data), .i_bg_issue(bg_issue), .i_bg_issue_rd(bg_issue_rd),
        .i_bg_wr_en(bg_wr_en), .i_bg_addr(bg_addr), .i_bg_data(bg_data), .o_bg_ready(),
        .i_dec_valid(i_dec_valid), .i_dec_rs_use(i_dec_rs_use), .i_dec_rs1(i_dec_rs1),
        .i_dec_rs2(i_dec_rs2), .i_dec_rs3(i_dec_rs3), .i_dec_rd_use(i_dec_rd_use),
        .i_dec_rd(i_dec_rd), .o_dec_stall(), .i_fp_instr(i_fp_instr),
        .i_flags_valid(i_flags_valid), .i_flags(i_flags), .i_csr_en(i_csr_en),
        .i_csr_we(i_csr_we), .i_csr_addr(i_csr_addr), .i_csr_wdata(i_csr_wdata),
        .o_csr_rdata(), .o_illegal(), .o_fflags(), .o_frm(), .o_fs(), .o_sd());

    always #5 i_clk_sys = ~i_clk_sys;

    function automatic fprs_pkg::fprs_word_t fcsr_of(input logic [2:0] r, input logic [4:0] f);
        return {24'h00_0000, r, f};
    endfunction : fcsr_of
    function automatic fprs_pkg::fprs_word_t ms_of(input fprs_pkg::fprs_fs_t s);
        return {s == `FPRS_FS_DIRTY, 16'h0000, s, 13'h0000};
    endfunction : ms_of
    task check(input fprs_pkg::fprs_word_t seen, input fprs_pkg::fprs_word_t exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // the strobe drops a cycle before the next access so no signal changes twice at once
    task csr(input logic we, input logic [11:0] a, input fprs_pkg::fprs_word_t wd);
        i_csr_en = 1'b1;
        i_csr_we = we;
        i_csr_addr = a;
        i_csr_wdata = wd;
        @(negedge i_clk_sys);
        rdv = csr_rdata;
        ill = illegal;
        i_csr_en = 1'b0;
        i_csr_we = 1'b0;
        @(negedge i_clk_sys);
    endtask : csr
    task wr(input fprs_pkg::fprs_ridx_t a, input fprs_pkg::fprs_word_t d);
        i_wr_en = 1'b1;
        i_wr_addr = a;
        i_wr_data = d;
        exp_rf[a] = d;
        @(negedge i_clk_sys);
        check(gpr_we, 0);
        check(rgpr_we, 1);
        check(rgpr_waddr, a);
        check(rgpr_wdata, d);
        i_wr_en = 1'b0;
        i_wr_data = ~d;
        @(negedge i_clk_sys);
    endtask : wr
    task rdchk(input fprs_pkg::fprs_ridx_t a, input fprs_pkg::fprs_ridx_t b,
               input fprs_pkg::fprs_ridx_t c);
        i_rd_addr_a = a;
        i_rd_addr_b = b;
        i_rd_addr_c = c;
        @(negedge i_clk_sys);
        check(rd_a, exp_rf[a]);
        check(rd_b, exp_rf[b]);
        check(rd_c, exp_rf[c]);
        check(rr_a, gpr_a);
        check(rr_b, gpr_b);
        check(rr_c, gpr_c);
    endtask : rdchk
    task query(input logic [2:0] u, input fprs_pkg::fprs_ridx_t r1, input logic du,
               input fprs_pkg::fprs_ridx_t d, input logic exp);
        i_dec_valid = 1'b1;
        i_dec_rs_use = u;
        i_dec_rs1 = r1;
        i_dec_rd_use = du;
        i_dec_rd = d;
        @(negedge i_clk_sys);
        check(dec_stall, exp);
    endtask : query

    initial begin
        #100000;
        num_errors = num_errors + 1;
        results;
    end

    initial begin
        gpr_a = $random(seed);
        gpr_b = $random(seed);
        gpr_c = $random(seed);
        repeat (10) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        check(fs, `FPRS_FS_OFF);
        check(sd, 0);
        check(fpu_clk_en, 1);
        check(bg_ready, 1);
        csr(1'b1, `FPRS_ADDR_FRM, 32'h0000_0007);
        check(ill, 1);
        check(frm, 0);
        csr(1'b0, `FPRS_ADDR_FCSR, 32'h0000_0000);
        check(ill, 1);
        check(rdv, 0);
        i_fp_instr = 1'b1;
        @(negedge i_clk_sys);
        i_fp_instr = 1'b0;
        check(illegal, 1);
        $display("test fp off done");
        csr(1'b1, `FPRS_ADDR_MSTATUS, ms_of(`FPRS_FS_INITIAL));
        check(fs, `FPRS_FS_INITIAL);
        check(sd, 0);
        csr(1'b1, `FPRS_ADDR_FCSR, 32'h0000_0065);
        check(ill, 0);
        check(frm, 3);
        check(fflags, 5);
        check(fs, `FPRS_FS_DIRTY);
        check(sd, 1);
        i_fp_instr = 1'b1;
        @(negedge i_clk_sys);
        i_fp_instr = 1'b0;
        check(illegal, 0);
        for (i = 0; i < 8; i = i + 1) begin
            x_frm = 3'($random(seed));
            x_ff = 5'($random(seed));
            rv = $random(seed);
            csr(1'b1, `FPRS_ADDR_FRM, {29'h0000_0000, x_frm});
            csr(1'b1, `FPRS_ADDR_FFLAGS, {27'h000_0000, x_ff});
            csr(1'b0, `FPRS_ADDR_FCSR, 32'h0000_0000);
            check(rdv, fcsr_of(x_frm, x_ff));
            csr(1'b1, `FPRS_ADDR_FCSR, rv);
            csr(1'b0, `FPRS_ADDR_FRM, 32'h0000_0000);
            check(rdv, {29'h0000_0000, rv[7:5]});
            csr(1'b0, `FPRS_ADDR_FFLAGS, 32'h0000_0000);
            check(rdv, {27'h000_0000, rv[4:0]});
        end
        $display("test csr views done");
        csr(1'b1, `FPRS_ADDR_FFLAGS, 32'h0000_0000);
        x_ff = 5'($random(seed));
        rv = $random(seed);
        i_flags_valid = 1'b1;
        i_flags = x_ff;
        @(negedge i_clk_sys);
        i_flags = rv[4:0];
        @(negedge i_clk_sys);
        check(fflags, x_ff | rv[4:0]);
        i_flags_valid = 1'b0;
        @(negedge i_clk_sys);
        i_csr_en = 1'b1;
        i_csr_we = 1'b1;
        i_csr_addr = `FPRS_ADDR_FFLAGS;
        i_csr_wdata = 32'h0000_0001;
        i_flags_valid = 1'b1;
        i_flags = 5'h10;
        @(negedge i_clk_sys);
        i_csr_en = 1'b0;
        i_csr_we = 1'b0;
        i_flags_valid = 1'b0;
        check(fflags, 5'h11);
        @(negedge i_clk_sys);
        $display("test flags done");
        csr(1'b1, `FPRS_ADDR_MSTATUS, ms_of(`FPRS_FS_CLEAN));
        check(fs, `FPRS_FS_CLEAN);
        check(sd, 0);
        wr(5'h03, $random(seed));
        check(fs, `FPRS_FS_DIRTY);
        csr(1'b0, `FPRS_ADDR_MSTATUS, 32'h0000_0000);
        check(rdv & 32'h8000_6000, 32'h8000_6000);
        for (i = 0; i < 32; i = i + 1) wr(fprs_pkg::fprs_ridx_t'(i), $random(seed));
        for (i = 0; i < 32; i = i + 1) begin
            rdchk(fprs_pkg::fprs_ridx_t'(i), fprs_pkg::fprs_ridx_t'(31 - i),
                  fprs_pkg::fprs_ridx_t'(i) ^ 5'h15);
        end
        $display("test register file done");
        i_core_sleep = 1'b1;
        @(negedge i_clk_sys);
        check(fpu_clk_en, 0);
        i_core_sleep = 1'b0;
        @(negedge i_clk_sys);
        check(fpu_clk_en, 1);
        $display("test sleep done");
        m_rd = 5'h04;
        m_res = $random(seed);
        m_start = 1'b1;
        @(negedge i_clk_sys);
        m_start = 1'b0;
        @(negedge i_clk_sys);
        query(3'b001, 5'h04, 1'b0, 5'h00, 1'b1);
        query(3'b001, 5'h05, 1'b0, 5'h00, 1'b0);
        query(3'b000, 5'h04, 1'b1, 5'h04, 1'b1);
        query(3'b000, 5'h04, 1'b0, 5'h04, 1'b0);
        i_dec_valid = 1'b0;
        m_fire = 1'b1;
        @(negedge i_clk_sys);
        rv = $random(seed);
        m_fire = 1'b0;
        i_wr_en = 1'b1;
        i_wr_addr = 5'h07;
        i_wr_data = rv;
        exp_rf[7] = rv;
        exp_rf[4] = m_res;
        @(negedge i_clk_sys);
        i_wr_en = 1'b0;
        check(bg_ready, 0);
        @(negedge i_clk_sys);
        query(3'b001, 5'h04, 1'b0, 5'h00, 1'b0);
        i_dec_valid = 1'b0;
        rdchk(5'h04, 5'h07, 5'h04);
        $display("test background done");
        results;
    end
endmodule : tb_top
